// >>> src/cskip_pkg.sv
package cskip_pkg;

   // Opcode fields of the compare-and-skip family (upper seven bits of the word).
   localparam logic [6:0] CSKIP_OP_LESS = 7'h30;
   localparam logic [6:0] CSKIP_OP_EQUAL = 7'h31;
   localparam logic [6:0] CSKIP_OP_GREATER = 7'h32;
   localparam int CSKIP_OP_MSB = 15;
   localparam int CSKIP_OP_LSB = 9;
   localparam int CSKIP_BANK_BIT = 8;

   // Highest file address that switches to indexed literal offset addressing.
   localparam logic [7:0] CSKIP_INDEX_LIMIT = 8'h5F;

   // Quadrature phase count of one instruction cycle.
   localparam int CSKIP_PHASES = 4;
   localparam logic [1:0] CSKIP_PHASE_RESET = 2'h0;

   // Compare kinds carried from decode to processing.
   typedef enum logic [1:0] {
      CSKIP_CMP_NONE = 2'h0,
      CSKIP_CMP_LESS = 2'h1,
      CSKIP_CMP_EQUAL = 2'h2,
      CSKIP_CMP_GREATER = 2'h3
   } cskip_cmp_t;

   // Data memory address request toward the file register space.
   typedef struct packed {
      logic valid;
      logic indexed;
      logic banked;
      logic [3:0] bank;
      logic [7:0] offset;
   } cskip_addr_t;

endpackage

// >>> src/cskip_phase.sv
`timescale 1ns/1ns
// Quadrature phase generator: one-hot Q1..Q4 strobes, one clock each, that
// divide the core clock into instruction cycles.
module cskip_phase
   import cskip_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   output logic [CSKIP_PHASES-1:0] phase
);

   // Whole state of the divider.
   typedef struct packed {
      logic [1:0] count;
   } cskip_phase_state_t;

   cskip_phase_state_t state;
   cskip_phase_state_t next_state;

   // Advance the count every clock and wrap after the last phase.
   always_comb begin
      next_state = state;
      next_state.count = state.count + 2'h1;
   end

   // Register the count.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state.count <= CSKIP_PHASE_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Decode the count to one-hot phase strobes.
   always_comb begin
      phase = '0;
      phase[state.count] = 1'b1;
   end

endmodule

// >>> src/cskip_core.sv
`timescale 1ns/1ns
// Contract
// - Decode greater compare 0110 010a, file low.
// - Decode less compare 0110 000a, file low.
// - Unsigned file minus working, no flags.
// - True relation discards fetched instruction as nop.
// - Bank bit zero access bank, else bank select.
// - Indexed mode when a=0, extended, f<=95.
// - Q1 decode, Q2 read, Q3 process, Q4 idle.
module cskip_core
   import cskip_pkg::*;
#(
   // Operand width and bank select width.
   parameter int DATA_W = 8,
   parameter int BANK_W = 4
)
(
   // Core clock and asynchronous active-low reset.
   input wire logic clk,
   input wire logic rst_b,
   // Instruction word from the decode stage; only looked at in an idle Q1.
   input wire logic [15:0] instr,
   input wire logic instr_valid,
   // Tells whether the already fetched next word starts a two-word instruction.
   input wire logic next_is_two_word,
   // Enables the indexed literal offset form for access bank operands.
   input wire logic extended_set,
   // Bank used when the operand bank bit is set.
   input wire logic [BANK_W-1:0] bank_select_register,
   // Operands: the working register and the read data of the file register.
   input wire logic [DATA_W-1:0] working_register,
   input wire logic [DATA_W-1:0] file_rdata,
   // Read request toward the file register space.
   output cskip_addr_t file_addr,
   // Write strobes of the datapath; this family never raises them.
   output logic file_write,
   output logic working_write,
   output logic status_write,
   // Program flow: the fetched word is being replaced by no-operation cycles.
   output logic discard,
   output logic busy,
   output logic skip_taken,
   // Quadrature phase strobes, Q1 in bit zero.
   output logic [CSKIP_PHASES-1:0] phase
);

   // Sequencer states, one-hot.
   // A corrupted code falls back to idle through the default branch below.
   typedef enum logic [3:0] {
      CSKIP_IDLE = 4'h1,
      CSKIP_EXEC = 4'h2,
      CSKIP_SKIP1 = 4'h4,
      CSKIP_SKIP2 = 4'h8
   } cskip_fsm_t;

   // Entire state of the block.
   typedef struct packed {
      // Sequencer position.
      cskip_fsm_t fsm;
      // Relation under test, latched at decode.
      cskip_cmp_t cmp;
      // Length of the instruction being discarded, latched in Q3.
      logic two_word;
      // File operand captured in Q2 so that Q3 compares a stable value.
      logic [DATA_W-1:0] file_value;
      // Registered read request.
      cskip_addr_t addr;
      // Registered discard level and one-cycle skip pulse.
      logic discard;
      logic skip_taken;
   } cskip_state_t;

   // Present and next copy of the whole state.
   cskip_state_t state;
   cskip_state_t next_state;

   // Phase strobes come from the shared divider.
   // They also leave as a port so the rest of the core follows the same phases.
   cskip_phase u_phase (
      .clk(clk),
      .rst_b(rst_b),
      .phase(phase)
   );

   // Phase strobes under short names.
   logic q1;
   logic q2;
   logic q3;
   logic q4;
   // Fields of the instruction word.
   logic [6:0] opcode;
   logic bank_bit;
   logic [7:0] file_offset;
   // Compare kind of the word at the input.
   cskip_cmp_t decoded;
   // True when the tested relation holds for the captured file operand and the working register.
   logic relation;
   // Difference with a borrow bit on top.
   logic [DATA_W:0] diff;

   // Name the phases; every action below is tied to one of them.
   assign q1 = phase[0];
   assign q2 = phase[1];
   assign q3 = phase[2];
   assign q4 = phase[3];
   // Slice the word; the opcode sits in the upper seven bits.
   assign opcode = instr[CSKIP_OP_MSB:CSKIP_OP_LSB];
   assign bank_bit = instr[CSKIP_BANK_BIT];
   assign file_offset = instr[7:0];

   // Opcode decode; anything else belongs to other decoders.
   // The equal form shares the encoding family and is decoded here too.
   always_comb begin
      unique case (opcode)
         CSKIP_OP_GREATER: decoded = CSKIP_CMP_GREATER;
         CSKIP_OP_LESS: decoded = CSKIP_CMP_LESS;
         CSKIP_OP_EQUAL: decoded = CSKIP_CMP_EQUAL;
         default: decoded = CSKIP_CMP_NONE;
      endcase
   end

   // Unsigned subtraction; the borrow bit gives less-than, zero gives equal.
   // The result feeds only the skip decision, never the status flags.
   // The working register is read directly; only its Q3 value matters.
   always_comb begin
      diff = {1'b0, state.file_value} - {1'b0, working_register};
      unique case (state.cmp)
         CSKIP_CMP_LESS: relation = diff[DATA_W];
         CSKIP_CMP_EQUAL: relation = (diff[DATA_W-1:0] == '0);
         CSKIP_CMP_GREATER: relation = !diff[DATA_W] && (diff[DATA_W-1:0] != '0);
         default: relation = 1'b0;
      endcase
   end

   // Sequencer: each skip state spans one instruction cycle of four phases; EXEC spans Q2 to Q4.
   // Leaving idle only on a Q1 edge and other states only on a Q4 edge keeps every cycle exactly four clocks long.
   always_comb begin
      next_state = state;
      next_state.skip_taken = 1'b0;
      unique case (state.fsm)
         CSKIP_IDLE: begin
            // Only a Q1 word of this family starts a compare; others pass by.
            // Q1 decodes a new word and forms the operand address.
            if (q1 && instr_valid && decoded != CSKIP_CMP_NONE) begin
               next_state.fsm = CSKIP_EXEC;
               next_state.cmp = decoded;
               next_state.addr.valid = 1'b1;
               next_state.addr.offset = file_offset;
               next_state.addr.banked = bank_bit;
               // The bank select register counts only for a banked operand.
               next_state.addr.bank = bank_bit ? 4'(bank_select_register) : 4'h0;
               next_state.addr.indexed = !bank_bit && extended_set &&
                  (file_offset <= CSKIP_INDEX_LIMIT);
            end
         end
         CSKIP_EXEC: begin
            // Q2 reads the file register; Q3 compares; Q4 writes nothing.
            if (q2) begin
               // Capturing here keeps a late change of the read data out of Q3.
               // The request drops after one cycle; the memory needs no more.
               next_state.file_value = file_rdata;
               next_state.addr.valid = 1'b0;
            end
            if (q3) begin
               // The length of the next word is taken while it is still at the input.
               next_state.two_word = next_is_two_word;
               if (relation) begin
                  next_state.discard = 1'b1;
                  next_state.skip_taken = 1'b1;
               end
            end
            if (q4) begin
               // Nothing is written back; only the path to the next cycle is chosen.
               next_state.fsm = state.discard ? CSKIP_SKIP1 : CSKIP_IDLE;
               next_state.cmp = CSKIP_CMP_NONE;
            end
         end
         CSKIP_SKIP1: begin
            // A whole cycle of no operation replaces the fetched word.
            // Discard stays high into the second nop when the word was long.
            if (q4) begin
               next_state.fsm = state.two_word ? CSKIP_SKIP2 : CSKIP_IDLE;
               next_state.discard = state.two_word;
            end
         end
         CSKIP_SKIP2: begin
            // Second word of a discarded long instruction is also a nop.
            // Dropping discard here hands the next Q1 back to normal decode.
            if (q4) begin
               next_state.fsm = CSKIP_IDLE;
               next_state.discard = 1'b0;
            end
         end
         default: begin
            // An illegal code returns to idle rather than locking the core.
            next_state.fsm = CSKIP_IDLE;
         end
      endcase
   end

   // Register the whole state.
   // Reset leaves the sequencer idle with no request and no discard pending.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state.fsm <= CSKIP_IDLE;
         state.cmp <= CSKIP_CMP_NONE;
         state.two_word <= 1'b0;
         state.file_value <= '0;
         state.addr <= '0;
         state.discard <= 1'b0;
         state.skip_taken <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // The compare never writes back; these strobes stay low by design.
   // They stay as ports so that the datapath sees an explicit no-write.
   assign file_write = 1'b0;
   assign working_write = 1'b0;
   assign status_write = 1'b0;
   // Address, discard and skip pulse come straight from flip-flops.
   assign file_addr = state.addr;
   assign discard = state.discard;
   assign skip_taken = state.skip_taken;
   // Busy is decoded from the state so the fetch side sees it without delay.
   assign busy = (state.fsm != CSKIP_IDLE);

endmodule

// >>> sim/cskip_sva.sv
`timescale 1ns/1ns
// Port checker for the compare core.
module cskip_sva
   import cskip_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] instr,
   input wire logic instr_valid,
   input wire logic extended_set,
   input wire logic [3:0] bank_select_register,
   input wire cskip_addr_t file_addr,
   input wire logic file_write,
   input wire logic working_write,
   input wire logic status_write,
   input wire logic discard,
   input wire logic busy,
   input wire logic skip_taken,
   input wire logic [CSKIP_PHASES-1:0] phase
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   no_write_a: assert property (!(file_write | working_write | status_write)) else $error("write seen");
   phase_ring_a: assert property (phase[3] |=> phase[0]) else $error("phase order");
   skip_q4_a: assert property (skip_taken |-> phase[3] && discard) else $error("skip timing");
   skip_len_a: assert property (skip_taken |-> discard[*5]) else $error("discard short");
   addr_q2_a: assert property ($rose(file_addr.valid) |-> phase[1] ##1 !file_addr.valid)
      else $error("read phase");
   take_gt_a: assert property (phase[0] && !busy && instr_valid && instr[15:9] == CSKIP_OP_GREATER
      |=> file_addr.valid && file_addr.offset == $past(instr[7:0])) else $error("greater decode");
   take_lt_a: assert property (phase[0] && !busy && instr_valid && instr[15:9] == CSKIP_OP_LESS
      |=> file_addr.valid && file_addr.banked == $past(instr[8])) else $error("less decode");
   bank_select_a: assert property (file_addr.valid && file_addr.banked
      |-> file_addr.bank == bank_select_register) else $error("bank wrong");
   index_mode_a: assert property (file_addr.valid |-> file_addr.indexed == (!file_addr.banked
      && extended_set && file_addr.offset <= CSKIP_INDEX_LIMIT)) else $error("index mode");
   skip_end_a: assert property ($fell(discard) |-> phase[0]) else $error("skip end");
   cover property (skip_taken);
   cover property (file_addr.valid && file_addr.indexed);
   cover property (discard[*8]);
endmodule

bind cskip_core cskip_sva u_sva (.clk, .rst_b, .instr, .instr_valid, .extended_set, .bank_select_register,
   .file_addr, .file_write, .working_write, .status_write, .discard, .busy, .skip_taken, .phase);

// >>> sim/testbench.sv
`timescale 1ns/1ns
module testbench;
   import cskip_pkg::*;
   logic clk = 0, rst_b = 0, iv = 0, two = 0, ext = 0;
   logic [15:0] instr = 16'h0000;
   logic [3:0] bank_sel = 4'h5;
   logic [7:0] wk = 8'h00, fdat = 8'h00;
   cskip_addr_t fa;
   logic fw, ww, sw, disc, busy, skip;
   logic [3:0] phase;
   int num_errors = 0, check_count = 0;
   // Free running core clock.
   always #5 clk = ~clk;
   cskip_core u_dut (.clk(clk), .rst_b(rst_b), .instr(instr), .instr_valid(iv), .next_is_two_word(two),
      .extended_set(ext), .bank_select_register(bank_sel), .working_register(wk), .file_rdata(fdat),
      .file_addr(fa), .file_write(fw), .working_write(ww), .status_write(sw), .discard(disc),
      .busy(busy), .skip_taken(skip), .phase(phase));
   task check(string nm, logic [15:0] exp, logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Waits for an idle Q1 so the next edge takes the word.
   task idle_q1();
      while (phase !== 4'h1 || busy !== 1'b0) @(posedge clk) #1;
   endtask
   // One compare; skip and its length are worked out here from the relation.
   task run(logic [6:0] op, logic a, logic [7:0] f, logic [7:0] fv, logic [7:0] wv, logic tw);
      logic rel;
      int n;
      rel = (op == CSKIP_OP_GREATER) ? fv > wv : (op == CSKIP_OP_LESS) ? fv < wv : fv == wv;
      n = 0;
      idle_q1();
      instr = {op, a, f};
      iv = 1;
      fdat = fv;
      wk = wv;
      two = tw;
      @(posedge clk) #1 iv = 0;
      check("addr", {a, !a && ext && f <= 8'h5F, f}, {fa.banked, fa.indexed, fa.offset});
      check("bank", a ? bank_sel : 4'h0, fa.bank);
      repeat (2) @(posedge clk) #1;
      check("skip", rel, skip);
      while (disc === 1'b1) begin
         n++;
         @(posedge clk) #1;
      end
      check("length", rel ? (tw ? 9 : 5) : 0, n);
      check("writes", 0, {fw, ww, sw});
   endtask
   task t_greater();
      run(CSKIP_OP_GREATER, 1, 8'h10, 8'h80, 8'h7F, 0);
      run(CSKIP_OP_GREATER, 1, 8'h11, 8'h7F, 8'h7F, 0);
      $display("greater done");
   endtask
   task t_less();
      ext = 1;
      run(CSKIP_OP_LESS, 0, 8'h5F, 8'h7F, 8'h80, 1);
      run(CSKIP_OP_LESS, 0, 8'h60, 8'hFF, 8'h00, 0);
      run(CSKIP_OP_EQUAL, 0, 8'h20, 8'h3C, 8'h3C, 1);
      $display("less done");
   endtask
   // A word outside the family must leave the core idle.
   task t_ignore();
      idle_q1();
      instr = 16'h6600;
      iv = 1;
      @(posedge clk) #1 iv = 0;
      check("idle", 0, {busy, fa.valid});
      $display("ignore done");
   endtask
   task tally_and_finish();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Reset for sixteen cycles, then the scenarios.
   initial begin
      repeat (16) @(posedge clk);
      #1 rst_b = 1;
      t_greater();
      t_less();
      t_ignore();
      tally_and_finish();
   end
   // The scenarios need under a hundred cycles; this cuts a hang short.
   initial begin
      #100000;
      num_errors++;
      tally_and_finish();
   end
endmodule
